// ### src/cpura_core_regs.sv
// Architectural registers and operand addressing of the CPU core
`default_nettype none
`include "cpura_consts.svh"
module cpura_core_regs (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  input wire logic i_acc_wr,
  input wire logic [7:0] i_acc_wdata,
  input wire logic i_b_wr,
  input wire logic [7:0] i_b_wdata,
  input wire logic i_cy_wr,
  input wire logic i_cy_val,
  input wire logic i_ac_wr,
  input wire logic i_ac_val,
  input wire logic i_ov_wr,
  input wire logic i_ov_val,
  input wire logic i_push,
  input wire logic i_pop,
  output logic o_stack_wr,
  output logic [7:0] o_sp,
  input wire logic i_ptr_wr,
  input wire logic [15:0] i_ptr_wdata,
  input wire logic i_ptr_inc,
  input wire cpura_pkg::cpura_mode_t i_mode,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_dir_field,
  input wire logic [1:0] i_ri_sel,
  input wire logic i_ind_ext,
  input wire logic [7:0] i_ri_value,
  input wire logic [15:0] i_pc,
  output logic [7:0] o_acc,
  output logic [7:0] o_b,
  output logic [7:0] o_flags,
  output logic [15:0] o_ptr,
  output logic o_ptr_sel,
  output logic o_pin_relocate,
  output logic [15:0] o_op_addr,
  output cpura_pkg::cpura_space_t o_op_space,
  output logic o_op_read_only,
  output logic [7:0] o_ri_loc,
  output logic [15:0] o_jump_target
);

  // ****************************************************
  // Declarations
  // ****************************************************
  logic [7:0] acc_reg, acc_next;
  logic [7:0] b_reg, b_next;
  logic [7:0] sp_reg, sp_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] aux_reg, aux_next;
  logic stack_wr_reg, stack_wr_next;
  logic [7:0] rdata_reg, rdata_next;
  logic hit_reg, hit_next;
  logic [15:0] ptr_cur, ptr_out_reg;
  logic [15:0] addr_c, addr_reg, jump_c, jump_reg;
  cpura_pkg::cpura_space_t space_c, space_reg;
  logic ro_c, ro_reg;
  logic [7:0] ri_loc_c, ri_loc_reg;
  logic wr_acc, wr_b, wr_sp, wr_flags, wr_aux, wr_dpl, wr_dph;

  // SFR write decode
  assign wr_acc = i_sfr_wr && (i_sfr_addr == `CPURA_ADDR_ACC);
  assign wr_b = i_sfr_wr && (i_sfr_addr == `CPURA_ADDR_B);
  assign wr_sp = i_sfr_wr && (i_sfr_addr == `CPURA_ADDR_SP);
  assign wr_flags = i_sfr_wr && (i_sfr_addr == `CPURA_ADDR_FLAGS);
  assign wr_aux = i_sfr_wr && (i_sfr_addr == `CPURA_ADDR_AUX);
  assign wr_dpl = i_sfr_wr && (i_sfr_addr == `CPURA_ADDR_DPL);
  assign wr_dph = i_sfr_wr && (i_sfr_addr == `CPURA_ADDR_DPH);

  // ****************************************************
  // Accumulator, operand register and stack pointer
  // ****************************************************
  // ALU writes win over a same-cycle SFR write: the instruction result is what software expects
  always_comb begin
    acc_next = acc_reg;
    b_next = b_reg;
    sp_next = sp_reg;
    stack_wr_next = 1'b0;
    if (i_acc_wr) begin
      acc_next = i_acc_wdata;
    end else if (wr_acc) begin
      acc_next = i_sfr_wdata;
    end
    if (i_b_wr) begin
      b_next = i_b_wdata;
    end else if (wr_b) begin
      b_next = i_sfr_wdata;
    end
    if (i_push) begin
      sp_next = sp_reg + 8'h01;
      stack_wr_next = 1'b1;
    end else if (i_pop) begin
      sp_next = sp_reg - 8'h01;
    end else if (wr_sp) begin
      sp_next = i_sfr_wdata;
    end
  end

  // Register stage
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg <= `CPURA_BYTE_RST;
      b_reg <= `CPURA_BYTE_RST;
      sp_reg <= `CPURA_SP_RST;
      stack_wr_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      b_reg <= b_next;
      sp_reg <= sp_next;
      stack_wr_reg <= stack_wr_next;
    end
  end

  // ****************************************************
  // Flag word and secondary control
  // ****************************************************
  // Hardware flag updates override a software write of the same bit
  always_comb begin
    flags_next = flags_reg;
    aux_next = aux_reg;
    if (wr_flags) begin
      flags_next = i_sfr_wdata;
    end
    if (i_cy_wr) begin
      flags_next[`CPURA_CY_BIT] = i_cy_val;
    end
    if (i_ac_wr) begin
      flags_next[`CPURA_AC_BIT] = i_ac_val;
    end
    if (i_ov_wr) begin
      flags_next[`CPURA_OV_BIT] = i_ov_val;
    end
    // Parity is never stored from a write; it follows the accumulator
    flags_next[`CPURA_P_BIT] = ^acc_next;
    if (wr_aux) begin
      aux_next = i_sfr_wdata & `CPURA_AUX_MASK;
    end
  end

  // Register stage
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_reg <= `CPURA_FLAGS_RST;
      aux_reg <= `CPURA_AUX_RST;
    end else begin
      flags_reg <= flags_next;
      aux_reg <= aux_next;
    end
  end

  // ****************************************************
  // Table address pointers
  // ****************************************************
  // Byte writes land in the pointer chosen by the current select bit
  cpura_ptr_bank #(
    .NUM_PTR(2)
  ) u_ptr_bank (
    .i_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_sel(aux_reg[`CPURA_DPS_BIT]),
    .i_wr16(i_ptr_wr),
    .i_wdata16(i_ptr_wdata),
    .i_wr_lo(wr_dpl),
    .i_wr_hi(wr_dph),
    .i_wbyte(i_sfr_wdata),
    .i_inc(i_ptr_inc),
    .o_ptr(ptr_cur)
  );

  // ****************************************************
  // Operand addressing
  // ****************************************************
  cpura_addr_gen u_addr_gen (
    .i_mode(i_mode),
    .i_opcode(i_opcode),
    .i_dir_field(i_dir_field),
    .i_ri_sel(i_ri_sel),
    .i_ind_ext(i_ind_ext),
    .i_ri_value(i_ri_value),
    .i_sp(sp_reg),
    .i_bank(flags_reg[`CPURA_RS1_BIT:`CPURA_RS0_BIT]),
    .i_acc(acc_reg),
    .i_ptr(ptr_cur),
    .i_pc(i_pc),
    .o_addr(addr_c),
    .o_space(space_c),
    .o_read_only(ro_c),
    .o_ri_loc(ri_loc_c),
    .o_jump_target(jump_c)
  );

  // ****************************************************
  // SFR read port
  // ****************************************************
  // Unmapped addresses answer zero with the hit flag low
  always_comb begin
    rdata_next = 8'h00;
    hit_next = i_sfr_rd;
    if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        `CPURA_ADDR_ACC: rdata_next = acc_reg;
        `CPURA_ADDR_B: rdata_next = b_reg;
        `CPURA_ADDR_SP: rdata_next = sp_reg;
        `CPURA_ADDR_FLAGS: rdata_next = flags_reg;
        `CPURA_ADDR_AUX: rdata_next = aux_reg & `CPURA_AUX_MASK;
        `CPURA_ADDR_DPL: rdata_next = ptr_cur[7:0];
        `CPURA_ADDR_DPH: rdata_next = ptr_cur[15:8];
        default: hit_next = 1'b0;
      endcase
    end
  end

  // Output registers; addressing results trail their request by one cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 8'h00;
      hit_reg <= 1'b0;
      ptr_out_reg <= `CPURA_PTR_RST;
      addr_reg <= 16'h0000;
      space_reg <= cpura_pkg::SPACE_NONE;
      ro_reg <= 1'b0;
      ri_loc_reg <= 8'h00;
      jump_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
      ptr_out_reg <= ptr_cur;
      addr_reg <= addr_c;
      space_reg <= space_c;
      ro_reg <= ro_c;
      ri_loc_reg <= ri_loc_c;
      jump_reg <= jump_c;
    end
  end

  assign o_acc = acc_reg;
  assign o_b = b_reg;
  assign o_sp = sp_reg;
  assign o_stack_wr = stack_wr_reg;
  assign o_flags = flags_reg;
  assign o_ptr_sel = aux_reg[`CPURA_DPS_BIT];
  assign o_pin_relocate = aux_reg[`CPURA_RELOC_BIT];
  assign o_sfr_rdata = rdata_reg;
  assign o_sfr_hit = hit_reg;
  assign o_ptr = ptr_out_reg;
  assign o_op_addr = addr_reg;
  assign o_op_space = space_reg;
  assign o_op_read_only = ro_reg;
  assign o_ri_loc = ri_loc_reg;
  assign o_jump_target = jump_reg;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence push_s;
    i_push;
  endsequence
  sequence aux_wr_s;
    i_sfr_wr && (i_sfr_addr == `CPURA_ADDR_AUX);
  endsequence
  sequence aux_rd_s;
    i_sfr_rd && !i_sfr_wr && (i_sfr_addr == `CPURA_ADDR_AUX);
  endsequence

  stack_preinc_a: assert property (push_s |=> o_stack_wr && (o_sp == $past(o_sp) + 8'h01))
    else $error("stack pointer not incremented before push write");
  stack_reset_a: assert property ($rose(i_rst_n) |-> o_sp == 8'h07)
    else $error("stack pointer not 07 after reset");
  operand_write_a: assert property (i_b_wr |=> o_b == $past(i_b_wdata))
    else $error("operand register missed a multiply/divide result");
  parity_track_a: assert property (o_flags[0] == ^o_acc)
    else $error("parity flag disagrees with accumulator");
  carry_bit_a: assert property (i_cy_wr |=> o_flags[7] == $past(i_cy_val))
    else $error("carry flag did not take Boolean result");
  half_carry_a: assert property (i_ac_wr |=> o_flags[6] == $past(i_ac_val))
    else $error("half-carry flag not recorded");
  select_write_a: assert property (aux_wr_s |=> o_ptr_sel == $past(i_sfr_wdata[0]))
    else $error("pointer select did not follow write");
  gf2_readback_a: assert property (aux_wr_s ##1 aux_rd_s |=> o_sfr_rdata[3] == $past(i_sfr_wdata[3], 2))
    else $error("general flag did not read back");
  aux_unused_a: assert property (aux_rd_s |=> (o_sfr_rdata & 8'h76) == 8'h00)
    else $error("unused control bits read nonzero");
  bank_reg_a: assert property (i_mode == cpura_pkg::MODE_REGISTER
      |=> o_op_addr == {11'h000, $past(o_flags[4:3]), $past(i_opcode[2:0])})
    else $error("register operand mapped to wrong bank");
  index_read_a: assert property (i_mode == cpura_pkg::MODE_INDEX_PC
      |=> o_op_read_only && o_op_space == cpura_pkg::SPACE_CODE
          && o_op_addr == $past(i_pc) + {8'h00, $past(o_acc)})
    else $error("indexed read address wrong");

endmodule : cpura_core_regs
`default_nettype wire

// ### pkg/cpura_consts.svh
// Constants for the CPU register and addressing block
`ifndef CPURA_CONSTS_SVH
`define CPURA_CONSTS_SVH

// Special-function addresses
`define CPURA_ADDR_SP 8'h81
`define CPURA_ADDR_DPL 8'h82
`define CPURA_ADDR_DPH 8'h83
`define CPURA_ADDR_AUX 8'ha2
`define CPURA_ADDR_FLAGS 8'hd0
`define CPURA_ADDR_ACC 8'he0
`define CPURA_ADDR_B 8'hf0
// Lowest special-function address in the direct space
`define CPURA_SFR_BASE 8'h80

// Reset values
`define CPURA_SP_RST 8'h07
`define CPURA_FLAGS_RST 8'h00
`define CPURA_AUX_RST 8'h00
`define CPURA_BYTE_RST 8'h00
`define CPURA_PTR_RST 16'h0000

// Flag word bit positions
`define CPURA_CY_BIT 7
`define CPURA_AC_BIT 6
`define CPURA_F0_BIT 5
`define CPURA_RS1_BIT 4
`define CPURA_RS0_BIT 3
`define CPURA_OV_BIT 2
`define CPURA_F1_BIT 1
`define CPURA_P_BIT 0

// Secondary control bit positions and implemented-bit mask
`define CPURA_RELOC_BIT 7
`define CPURA_GF2_BIT 3
`define CPURA_DPS_BIT 0
`define CPURA_AUX_MASK 8'h89

`endif

// ### pkg/cpura_pkg.sv
// Types shared by the CPU register and addressing block
`default_nettype none
package cpura_pkg;

  // Operand addressing mode requested by decode
  typedef enum logic [3:0] {
    MODE_NONE,
    MODE_DIRECT,
    MODE_INDIRECT8,
    MODE_INDIRECT16,
    MODE_REGISTER,
    MODE_IMPLICIT,
    MODE_IMMEDIATE,
    MODE_INDEX_PTR,
    MODE_INDEX_PC,
    MODE_JUMP_INDEX
  } cpura_mode_t;

  // Address space that an operand address points into
  typedef enum logic [2:0] {
    SPACE_NONE,
    SPACE_IRAM,
    SPACE_SFR,
    SPACE_XRAM,
    SPACE_CODE
  } cpura_space_t;

endpackage : cpura_pkg
`default_nettype wire

// ### src/cpura_ptr_bank.sv
// Dual 16-bit table address pointer sharing one set of addresses
`default_nettype none
`include "cpura_consts.svh"
module cpura_ptr_bank #(
  parameter int NUM_PTR = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sel,
  input wire logic i_wr16,
  input wire logic [15:0] i_wdata16,
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic [7:0] i_wbyte,
  input wire logic i_inc,
  output logic [15:0] o_ptr
);

  logic [15:0] ptr_reg [NUM_PTR];

  // ****************************************************
  // Pointer instances
  // ****************************************************
  for (genvar g = 0; g < NUM_PTR; g++) begin : g_ptr
    logic [15:0] ptr_next;
    logic hit;
    assign hit = (32'(i_sel) == g);

    // Only the selected instance sees any access
    always_comb begin
      ptr_next = ptr_reg[g];
      if (hit) begin
        if (i_wr16) begin
          ptr_next = i_wdata16;
        end else if (i_inc) begin
          ptr_next = ptr_reg[g] + 16'h0001;
        end else begin
          if (i_wr_lo) begin
            ptr_next[7:0] = i_wbyte;
          end
          if (i_wr_hi) begin
            ptr_next[15:8] = i_wbyte;
          end
        end
      end
    end

    // Register stage
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        ptr_reg[g] <= `CPURA_PTR_RST;
      end else begin
        ptr_reg[g] <= ptr_next;
      end
    end
  end

  // Reads follow the select bit too
  assign o_ptr = ptr_reg[i_sel];

endmodule : cpura_ptr_bank
`default_nettype wire

// ### src/cpura_addr_gen.sv
// Operand address generation for all addressing modes
`default_nettype none
`include "cpura_consts.svh"
module cpura_addr_gen (
  input wire cpura_pkg::cpura_mode_t i_mode,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_dir_field,
  input wire logic [1:0] i_ri_sel,
  input wire logic i_ind_ext,
  input wire logic [7:0] i_ri_value,
  input wire logic [7:0] i_sp,
  input wire logic [1:0] i_bank,
  input wire logic [7:0] i_acc,
  input wire logic [15:0] i_ptr,
  input wire logic [15:0] i_pc,
  output logic [15:0] o_addr,
  output cpura_pkg::cpura_space_t o_space,
  output logic o_read_only,
  output logic [7:0] o_ri_loc,
  output logic [15:0] o_jump_target
);

  // Location of R0 or R1 in the selected bank
  assign o_ri_loc = {3'h0, i_bank, 2'h0, i_ri_sel[0]};
  // Indexed jump target
  assign o_jump_target = i_ptr + {8'h00, i_acc};

  // Mode decode
  always_comb begin
    o_addr = 16'h0000;
    o_space = cpura_pkg::SPACE_NONE;
    o_read_only = 1'b0;
    unique case (i_mode)
      cpura_pkg::MODE_NONE: begin
      end
      cpura_pkg::MODE_DIRECT: begin
        o_addr = {8'h00, i_dir_field};
        o_space = (i_dir_field < `CPURA_SFR_BASE) ? cpura_pkg::SPACE_IRAM : cpura_pkg::SPACE_SFR;
      end
      cpura_pkg::MODE_INDIRECT8: begin
        // Selector 2 or 3 means the stack pointer, which stays internal
        o_addr = {8'h00, i_ri_sel[1] ? i_sp : i_ri_value};
        o_space = (i_ind_ext && !i_ri_sel[1]) ? cpura_pkg::SPACE_XRAM : cpura_pkg::SPACE_IRAM;
      end
      cpura_pkg::MODE_INDIRECT16: begin
        o_addr = i_ptr;
        o_space = cpura_pkg::SPACE_XRAM;
      end
      cpura_pkg::MODE_REGISTER: begin
        o_addr = {11'h000, i_bank, i_opcode[2:0]};
        o_space = cpura_pkg::SPACE_IRAM;
      end
      cpura_pkg::MODE_IMPLICIT: begin
        // Opcode bit 0 picks the pointer, otherwise the accumulator
        o_addr = i_opcode[0] ? i_ptr : {8'h00, `CPURA_ADDR_ACC};
        o_space = i_opcode[0] ? cpura_pkg::SPACE_XRAM : cpura_pkg::SPACE_SFR;
      end
      cpura_pkg::MODE_IMMEDIATE: begin
        o_addr = i_pc + 16'h0001;
        o_space = cpura_pkg::SPACE_CODE;
        o_read_only = 1'b1;
      end
      cpura_pkg::MODE_INDEX_PTR: begin
        o_addr = i_ptr + {8'h00, i_acc};
        o_space = cpura_pkg::SPACE_CODE;
        o_read_only = 1'b1;
      end
      cpura_pkg::MODE_INDEX_PC: begin
        o_addr = i_pc + {8'h00, i_acc};
        o_space = cpura_pkg::SPACE_CODE;
        o_read_only = 1'b1;
      end
      cpura_pkg::MODE_JUMP_INDEX: begin
        o_addr = o_jump_target;
        o_space = cpura_pkg::SPACE_CODE;
        o_read_only = 1'b1;
      end
      default: begin
      end
    endcase
  end

endmodule : cpura_addr_gen
`default_nettype wire

// ### sim/cpura_cpu_model.sv
// Decode-side model that issues special-function register accesses
`default_nettype none
module cpura_cpu_model (
  input wire logic i_ref_clk,
  input wire logic [7:0] i_sfr_rdata,
  input wire logic i_sfr_hit,
  output logic o_sfr_wr,
  output logic o_sfr_rd,
  output logic [7:0] o_sfr_addr,
  output logic [7:0] o_sfr_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idles at time zero
  initial begin
    o_sfr_wr = 1'b0;
    o_sfr_rd = 1'b0;
    o_sfr_addr = 8'h00;
    o_sfr_wdata = 8'h00;
  end

  // Entered just after a rising edge; an idle edge follows so the strobe is never re-raised in the same step
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    o_sfr_wr <= 1'b1;
    o_sfr_addr <= a;
    o_sfr_wdata <= d;
    @(posedge i_ref_clk);
    o_sfr_wr <= 1'b0;
    o_sfr_wdata <= ~d; // Released data must not look still valid
    @(posedge i_ref_clk);
  endtask : sfr_write

  // Write, then read the same address at the very next edge, as decode may issue them back to back
  task automatic sfr_wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic h);
    o_sfr_wr <= 1'b1;
    o_sfr_addr <= a;
    o_sfr_wdata <= d;
    @(posedge i_ref_clk);
    o_sfr_wr <= 1'b0;
    o_sfr_rd <= 1'b1;
    o_sfr_wdata <= ~d;
    @(posedge i_ref_clk);
    o_sfr_rd <= 1'b0;
    @(posedge i_ref_clk);
    q = i_sfr_rdata;
    h = i_sfr_hit;
  endtask : sfr_wr_rd

  // Read data stands one cycle, so it is taken at the edge after the strobe
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d, output logic h);
    o_sfr_rd <= 1'b1;
    o_sfr_addr <= a;
    @(posedge i_ref_clk);
    o_sfr_rd <= 1'b0;
    @(posedge i_ref_clk);
    d = i_sfr_rdata;
    h = i_sfr_hit;
  endtask : sfr_read
endmodule : cpura_cpu_model
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the CPU register and addressing block
`default_nettype none
`include "cpura_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_ref_clk, i_rst_n, i_sfr_wr, i_sfr_rd, o_sfr_hit, i_acc_wr, i_b_wr, i_cy_wr, i_cy_val, i_ac_wr;
  logic i_ac_val, i_ov_wr, i_ov_val, i_push, i_pop, o_stack_wr, i_ptr_wr, i_ptr_inc, i_ind_ext, o_ptr_sel;
  logic o_pin_relocate, o_op_read_only, rd_h;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, i_acc_wdata, i_b_wdata, o_sp, i_opcode, i_dir_field;
  logic [7:0] i_ri_value, o_acc, o_b, o_flags, o_ri_loc, rd_d;
  logic [1:0] i_ri_sel;
  logic [15:0] i_ptr_wdata, i_pc, o_ptr, o_op_addr, o_jump_target;
  cpura_pkg::cpura_mode_t i_mode;
  cpura_pkg::cpura_space_t o_op_space;
  int errors, n_checks;
  logic [7:0] pvals [6] = '{8'h01, 8'h03, 8'h80, 8'hfe, 8'hff, 8'h10};

  typedef struct packed {
    cpura_pkg::cpura_mode_t md;
    logic [7:0] opc;
    logic [7:0] dir;
    logic [1:0] ri;
    logic ext;
    logic [15:0] addr;
    cpura_pkg::cpura_space_t spc;
    logic ro;
  } cpura_mrow_t;
  cpura_mrow_t rows [14];

  cpura_core_regs dut (
    .i_ref_clk, .i_rst_n, .i_sfr_wr, .i_sfr_rd, .i_sfr_addr, .i_sfr_wdata, .o_sfr_rdata, .o_sfr_hit,
    .i_acc_wr, .i_acc_wdata, .i_b_wr, .i_b_wdata, .i_cy_wr, .i_cy_val, .i_ac_wr, .i_ac_val, .i_ov_wr,
    .i_ov_val, .i_push, .i_pop, .o_stack_wr, .o_sp, .i_ptr_wr, .i_ptr_wdata, .i_ptr_inc, .i_mode, .i_opcode,
    .i_dir_field, .i_ri_sel, .i_ind_ext, .i_ri_value, .i_pc, .o_acc, .o_b, .o_flags, .o_ptr, .o_ptr_sel,
    .o_pin_relocate, .o_op_addr, .o_op_space, .o_op_read_only, .o_ri_loc, .o_jump_target
  );

  cpura_cpu_model u_cpu (
    .i_ref_clk, .i_sfr_rdata(o_sfr_rdata), .i_sfr_hit(o_sfr_hit), .o_sfr_wr(i_sfr_wr),
    .o_sfr_rd(i_sfr_rd), .o_sfr_addr(i_sfr_addr), .o_sfr_wdata(i_sfr_wdata)
  );

  // Free-running 20 MHz reference
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Write a register, read it back, compare data and hit
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e, input logic h);
    u_cpu.sfr_wr_rd(a, d, rd_d, rd_h);
    chk(16'(rd_d), 16'(e));
    chk(16'(rd_h), 16'(h));
  endtask : wr_rd

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // Whole sequence needs about 130 cycles; a hang is cut at 4000
  initial begin
    repeat (4000) @(posedge i_ref_clk);
    errors++;
    wrap_up();
  end

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    i_rst_n = 1'b0;
    {i_acc_wr, i_b_wr, i_cy_wr, i_cy_val, i_ac_wr, i_ac_val, i_ov_wr, i_ov_val} = 8'h00;
    {i_push, i_pop, i_ptr_wr, i_ptr_inc, i_ind_ext, i_ri_sel} = 7'h00;
    {i_acc_wdata, i_b_wdata, i_opcode, i_dir_field, i_ri_value} = 40'h0;
    {i_ptr_wdata, i_pc} = 32'h0;
    i_mode = cpura_pkg::MODE_NONE;
    errors = 0;
    n_checks = 0;
    // Expected with bank 3, stack top 30, acc 10, pointer 1235, pc 2000, Ri 44
    rows = '{
      '{cpura_pkg::MODE_DIRECT, 8'h00, 8'h7f, 2'h0, 1'b0, 16'h007f, cpura_pkg::SPACE_IRAM, 1'b0},
      '{cpura_pkg::MODE_DIRECT, 8'h00, 8'h90, 2'h0, 1'b0, 16'h0090, cpura_pkg::SPACE_SFR, 1'b0},
      '{cpura_pkg::MODE_INDIRECT8, 8'h00, 8'h00, 2'h0, 1'b0, 16'h0044, cpura_pkg::SPACE_IRAM, 1'b0},
      '{cpura_pkg::MODE_INDIRECT8, 8'h00, 8'h00, 2'h2, 1'b0, 16'h0030, cpura_pkg::SPACE_IRAM, 1'b0},
      '{cpura_pkg::MODE_INDIRECT8, 8'h00, 8'h00, 2'h1, 1'b1, 16'h0044, cpura_pkg::SPACE_XRAM, 1'b0},
      '{cpura_pkg::MODE_INDIRECT16, 8'h00, 8'h00, 2'h0, 1'b0, 16'h1235, cpura_pkg::SPACE_XRAM, 1'b0},
      '{cpura_pkg::MODE_REGISTER, 8'h2d, 8'h00, 2'h0, 1'b0, 16'h001d, cpura_pkg::SPACE_IRAM, 1'b0},
      '{cpura_pkg::MODE_IMPLICIT, 8'he4, 8'h00, 2'h0, 1'b0, 16'h00e0, cpura_pkg::SPACE_SFR, 1'b0},
      '{cpura_pkg::MODE_IMPLICIT, 8'ha3, 8'h00, 2'h0, 1'b0, 16'h1235, cpura_pkg::SPACE_XRAM, 1'b0},
      '{cpura_pkg::MODE_IMMEDIATE, 8'h00, 8'h00, 2'h0, 1'b0, 16'h2001, cpura_pkg::SPACE_CODE, 1'b1},
      '{cpura_pkg::MODE_INDEX_PTR, 8'h00, 8'h00, 2'h0, 1'b0, 16'h1245, cpura_pkg::SPACE_CODE, 1'b1},
      '{cpura_pkg::MODE_INDEX_PC, 8'h00, 8'h00, 2'h0, 1'b0, 16'h2010, cpura_pkg::SPACE_CODE, 1'b1},
      '{cpura_pkg::MODE_JUMP_INDEX, 8'h00, 8'h00, 2'h0, 1'b0, 16'h1245, cpura_pkg::SPACE_CODE, 1'b1},
      '{cpura_pkg::MODE_NONE, 8'h00, 8'h00, 2'h0, 1'b0, 16'h0000, cpura_pkg::SPACE_NONE, 1'b0}
    };
    tick(16);
    i_rst_n <= 1'b1;
    tick(2);
    chk(16'(o_sp), 16'h0007);
    chk(16'(o_flags), 16'h0000);
    chk(16'(o_ptr_sel), 16'h0000);
    // Register map: read-only and unimplemented bits, unmapped address
    wr_rd(8'ha2, 8'hff, 8'h89, 1'b1);
    chk(16'({o_ptr_sel, o_pin_relocate}), 16'h0003);
    wr_rd(8'ha2, 8'h08, 8'h08, 1'b1);
    wr_rd(8'hd0, 8'hff, 8'hfe, 1'b1);
    wr_rd(`CPURA_ADDR_B, 8'ha5, 8'ha5, 1'b1);
    wr_rd(`CPURA_ADDR_ACC, 8'h97, 8'h97, 1'b1);
    chk(16'(o_flags[0]), 16'h0001);
    wr_rd(`CPURA_ADDR_SP, 8'h30, 8'h30, 1'b1);
    wr_rd(`CPURA_ADDR_DPL, 8'h34, 8'h34, 1'b1);
    wr_rd(`CPURA_ADDR_DPH, 8'h12, 8'h12, 1'b1);
    wr_rd(8'h55, 8'h77, 8'h00, 1'b0);
    // Push raises the top and strobes the write there on the same edge; pop undoes it
    i_push <= 1'b1;
    tick(1);
    i_push <= 1'b0;
    tick(1);
    chk(16'({o_stack_wr, o_sp}), 16'h0131);
    tick(1);
    chk(16'(o_stack_wr), 16'h0000);
    i_pop <= 1'b1;
    tick(1);
    i_pop <= 1'b0;
    tick(2);
    chk(16'(o_sp), 16'h0030);
    // Parity follows every accumulator load
    foreach (pvals[k]) begin
      i_acc_wr <= 1'b1;
      i_acc_wdata <= pvals[k];
      tick(1);
      i_acc_wr <= 1'b0;
      tick(2);
      chk({o_acc, 7'h0, o_flags[0]}, {pvals[k], 7'h0, ^pvals[k]});
    end
    // Hardware loads beat a same-cycle software write of the same register
    {i_cy_wr, i_cy_val, i_ac_wr, i_ac_val, i_ov_wr, i_ov_val} <= 6'h3f;
    u_cpu.sfr_write(8'hd0, 8'h18);
    {i_cy_wr, i_ac_wr, i_ov_wr} <= 3'h0;
    tick(2);
    chk(16'(o_flags), 16'h00dd);
    i_b_wr <= 1'b1;
    i_b_wdata <= 8'h3c;
    u_cpu.sfr_write(`CPURA_ADDR_B, 8'hc3);
    i_b_wr <= 1'b0;
    tick(2);
    chk(16'(o_b), 16'h003c);
    // ALU load of the accumulator beats a same-cycle software write
    i_acc_wr <= 1'b1;
    u_cpu.sfr_write(`CPURA_ADDR_ACC, 8'h5a);
    i_acc_wr <= 1'b0;
    tick(2);
    chk(16'(o_acc), 16'h0010);
    // Second pointer shares the byte addresses; first keeps its value
    u_cpu.sfr_write(8'ha2, 8'h01);
    i_ptr_wr <= 1'b1;
    i_ptr_wdata <= 16'h01ff;
    tick(1);
    i_ptr_wr <= 1'b0;
    tick(2);
    chk(o_ptr, 16'h01ff);
    u_cpu.sfr_read(`CPURA_ADDR_DPH, rd_d, rd_h);
    chk(16'(rd_d), 16'h0001);
    u_cpu.sfr_write(8'ha2, 8'h00);
    i_ptr_inc <= 1'b1;
    tick(1);
    i_ptr_inc <= 1'b0;
    tick(2);
    chk(o_ptr, 16'h1235);
    // Addressing modes from the row table
    i_pc <= 16'h2000;
    i_ri_value <= 8'h44;
    foreach (rows[k]) begin
      i_mode <= rows[k].md;
      i_opcode <= rows[k].opc;
      i_dir_field <= rows[k].dir;
      i_ri_sel <= rows[k].ri;
      i_ind_ext <= rows[k].ext;
      tick(2);
      chk(o_op_addr, rows[k].addr);
      chk(16'(o_op_read_only), 16'(rows[k].ro));
      chk(16'(o_op_space), 16'(rows[k].spc));
    end
    chk(o_jump_target, 16'h1245);
    chk(16'(o_ri_loc), 16'h0018);
    // Second reset in mid-run restores stack top and flags
    i_rst_n <= 1'b0;
    tick(2);
    chk({o_sp, o_flags}, 16'h0700);
    chk(16'(o_op_space), 16'(cpura_pkg::SPACE_NONE));
    i_rst_n <= 1'b1;
    tick(2);
    chk({o_sp, o_acc}, 16'h0700);
    chk(o_ptr, 16'h0000);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
